// [hw/csr_defs.vh]
// Purpose: Constants for the card state park and resume command handler
// Assumes: Command bytes arrive already deframed from the card interface
// Notes: Status words are two bytes, first byte in the upper half
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// ==========================================
// Status words
`define CSR_SW_OK 16'h9000
`define CSR_SW_COND 16'h6985
`define CSR_SW_TOKEN 16'h6982
`define CSR_SW_MINBIG 16'h9864
`define CSR_SW_PARAM 16'h6b00
// ==========================================
// Command layout
`define CSR_PARK_LC 8'h04
`define CSR_PARK_LE 8'h0a
`define CSR_RESUME_LC 8'h08
`define CSR_P1_OP_BIT 0
`define CSR_SELECT_BY_NAME 8'h04
`define CSR_TOKEN_BYTES 8
`define CSR_RESP_BYTES 4'ha
// ==========================================
// Reset values
`define CSR_MAXDUR_RST 16'h0418
`define CSR_LFSR_SEED 64'h0000000000000001
// ==========================================
// Duration units
`define CSR_UNIT_SEC 8'h00
`define CSR_UNIT_10DAY 8'h04
// ==========================================
// Command classes seen from the decoder
`define CSR_CMD_PARK 3'h0
`define CSR_CMD_SELECT 3'h1
`define CSR_CMD_READ_BIN 3'h2
`define CSR_CMD_READ_REC 3'h3
`define CSR_CMD_CAPDECL 3'h4
`define CSR_CMD_OTHER 3'h7
// ==========================================
// Register map (AXI4-Lite byte addresses)
`define CSR_A_CTRL 4'h0
`define CSR_A_STATUS 4'h4
`define CSR_A_MAXDUR 4'h8
`define CSR_A_SEED 4'hc
`endif

// [hw/csr_handler.v]
// Purpose: Executes state park and resume commands inside the card
// Assumes: Command bytes come from card logic on aclk; nonvolatile store is external
// Notes: Store requests pulse for one cycle; store completion is assumed immediate
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "csr_defs.vh"

module csr_handler #(
	parameter STATE_W = 64
) (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Command from card interface: header then data bytes
	input wire cmd_valid,
	input wire [2:0] cmd_class,
	input wire [7:0] cmd_p1,
	input wire [7:0] cmd_p2,
	input wire [7:0] cmd_lc,
	input wire [7:0] cmd_le,
	input wire [95:0] cmd_data,
	output wire cmd_ready,
	// Response to card interface
	output reg rsp_valid,
	output reg [15:0] rsp_sw,
	output reg [79:0] rsp_data,
	output reg [3:0] rsp_len,
	output reg rsp_proactive_ok,
	// Session conditions
	input wire proactive_active,
	input wire bic_open,
	input wire secure_in_use,
	// Live card state and nonvolatile image
	input wire [STATE_W-1:0] live_state,
	output reg [STATE_W-1:0] saved_state,
	output reg save_pulse,
	output reg restore_pulse,
	output reg discard_pulse,
	output reg erase_pulse,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);
	// ==========================================
	// Duration helpers
	// Rank a two-byte duration in seconds so that units can be compared
	function [31:0] dur_sec;
		input [15:0] d;
		reg [31:0] mul;
		begin
			mul = 32'd1;
			case (d[15:8])
				8'h01: mul = 32'd60;
				8'h02: mul = 32'd3600;
				8'h03: mul = 32'd86400;
				8'h04: mul = 32'd864000;
				default: mul = 32'd1;
			endcase
			dur_sec = mul * {24'h000000, d[7:0]};
		end
	endfunction

	function unit_ok;
		input [15:0] d;
		begin
			unit_ok = (d[15:8] <= `CSR_UNIT_10DAY);
		end
	endfunction

	// ==========================================
	// Registers
	reg ctrl_deny_q;
	reg [15:0] max_dur_q;
	reg [63:0] lfsr_q;
	reg [63:0] token_q;
	reg held_q;
	// Counters wrap; software reads them only as a rough health view
	reg [7:0] cnt_park_q;
	reg [7:0] cnt_fail_q;

	wire [15:0] min_req = cmd_data[95:80];
	wire [15:0] max_req = cmd_data[79:64];
	wire [63:0] rx_token = cmd_data[95:32];
	wire is_resume = cmd_p1[`CSR_P1_OP_BIT];
	// Reserved P1 bits and a nonzero P2 are refused before any state changes
	wire p1_bad = (cmd_p1[7:1] != 7'h00) || (cmd_p2 != 8'h00);
	// Grant the terminal maximum when it fits, else its minimum: both lie in range
	wire [15:0] grant = (dur_sec(max_req) <= dur_sec(max_dur_q)) ? max_req : min_req;
	wire allowed_pre = (cmd_class == `CSR_CMD_READ_BIN) || (cmd_class == `CSR_CMD_READ_REC) ||
		(cmd_class == `CSR_CMD_CAPDECL) ||
		((cmd_class == `CSR_CMD_SELECT) && (cmd_p1 != `CSR_SELECT_BY_NAME));

	// ==========================================
	// Refusal decoding
	// Busy checks outrank the duration check so a busy card never reveals its limit
	wire park_busy = proactive_active || bic_open || secure_in_use;
	wire dur_bad = !unit_ok(min_req) || !unit_ok(max_req) ||
		(dur_sec(min_req) > dur_sec(max_dur_q));

	// Every command is answered in one cycle, so the interface never stalls
	assign cmd_ready = 1'b1;

	// ==========================================
	// Command execution; one-cycle turnaround
	always @(posedge aclk) begin
		if (!aresetn) begin
			rsp_valid <= 1'b0;
			rsp_sw <= 16'h0000;
			rsp_data <= 80'h0;
			rsp_len <= 4'h0;
			rsp_proactive_ok <= 1'b1;
			saved_state <= {STATE_W{1'b0}};
			save_pulse <= 1'b0;
			restore_pulse <= 1'b0;
			discard_pulse <= 1'b0;
			erase_pulse <= 1'b0;
			token_q <= 64'h0;
			held_q <= 1'b0;
			lfsr_q <= `CSR_LFSR_SEED;
			cnt_park_q <= 8'h00;
			cnt_fail_q <= 8'h00;
		end else begin
			// Free-running LFSR from the fixed reset seed; software writes to the seed address are ignored
			lfsr_q <= {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
			rsp_valid <= 1'b0;
			save_pulse <= 1'b0;
			restore_pulse <= 1'b0;
			discard_pulse <= 1'b0;
			erase_pulse <= 1'b0;
			// A refused command still answers in one cycle, with its own status word and no response data
			if (cmd_valid) begin
				rsp_valid <= 1'b1;
				rsp_len <= 4'h0;
				rsp_data <= 80'h0;
				rsp_proactive_ok <= 1'b1;
				rsp_sw <= `CSR_SW_OK;
				if (cmd_class == `CSR_CMD_PARK) begin
					if (p1_bad) begin
						rsp_sw <= `CSR_SW_PARAM;
						cnt_fail_q <= cnt_fail_q + 8'h01;
					end else if (is_resume) begin
						// A resume with valid P1 and P2 ends the held state, so a guessed token gets one try only
						held_q <= 1'b0;
						erase_pulse <= held_q;
						if (!held_q) begin
							rsp_sw <= `CSR_SW_COND;
							cnt_fail_q <= cnt_fail_q + 8'h01;
						end else if (rx_token != token_q) begin
							rsp_sw <= `CSR_SW_TOKEN;
							cnt_fail_q <= cnt_fail_q + 8'h01;
						end else begin
							restore_pulse <= 1'b1;
							discard_pulse <= 1'b1;
						end
					end else if (park_busy) begin
						rsp_sw <= `CSR_SW_COND;
						cnt_fail_q <= cnt_fail_q + 8'h01;
					end else if (ctrl_deny_q) begin
						rsp_sw <= `CSR_SW_COND;
						cnt_fail_q <= cnt_fail_q + 8'h01;
					end else if (dur_bad) begin
						rsp_sw <= `CSR_SW_MINBIG;
						cnt_fail_q <= cnt_fail_q + 8'h01;
					end else begin
						// Token is this cycle's LFSR word, never seen by the terminal before
						token_q <= lfsr_q;
						saved_state <= live_state;
						save_pulse <= 1'b1;
						held_q <= 1'b1;
						rsp_data <= {grant, lfsr_q};
						rsp_len <= `CSR_RESP_BYTES;
						rsp_proactive_ok <= 1'b0;
						cnt_park_q <= cnt_park_q + 8'h01;
					end
				end else if (held_q && !allowed_pre) begin
					held_q <= 1'b0;
					erase_pulse <= 1'b1;
				end else if (held_q) begin
					// Allowed command: held state kept, its effects dropped on a good resume
				end
			end
		end
	end

	// ==========================================
	// AXI4-Lite slave: write when both address and data present
	// Unmapped addresses answer with a slave error so stray accesses show up
	reg [3:0] aw_q;
	reg aw_have_q;
	reg [31:0] w_q;
	reg w_have_q;
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire [3:0] wa = aw_have_q ? aw_q : s_axi_awaddr;
	wire [31:0] wd = w_have_q ? w_q : s_axi_wdata;
	wire aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
	wire w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_q <= 4'h0;
			aw_have_q <= 1'b0;
			w_q <= 32'h0;
			w_have_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0;
			ctrl_deny_q <= 1'b0;
			max_dur_q <= `CSR_MAXDUR_RST;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (aw_ok && w_ok) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (wa)
					`CSR_A_CTRL: begin
						if (s_axi_wstrb[0])
							ctrl_deny_q <= wd[0];
					end
					`CSR_A_MAXDUR: begin
						if (s_axi_wstrb[0])
							max_dur_q[7:0] <= wd[7:0];
						if (s_axi_wstrb[1])
							max_dur_q[15:8] <= wd[15:8];
					end
					`CSR_A_STATUS: s_axi_bresp <= 2'b00;
					`CSR_A_SEED: s_axi_bresp <= 2'b00;
					default: s_axi_bresp <= 2'b10;
				endcase
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_q <= s_axi_awaddr;
					aw_have_q <= 1'b1;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_q <= s_axi_wdata;
					w_have_q <= 1'b1;
				end
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`CSR_A_CTRL: s_axi_rdata <= {31'h0, ctrl_deny_q};
					`CSR_A_STATUS: s_axi_rdata <= {15'h0, held_q, cnt_fail_q, cnt_park_q};
					`CSR_A_MAXDUR: s_axi_rdata <= {16'h0, max_dur_q};
					`CSR_A_SEED: s_axi_rdata <= lfsr_q[31:0];
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
		end
	end
endmodule

// [tb/csr_handler_sva.sv]
// Purpose: Port checks of the park and resume handler
// Assumes: One clock, synchronous active-low reset
// Notes: Held state is internal, so token bookkeeping is left to the bench
`timescale 1ns/1ps
module csr_handler_sva #(
	parameter STATE_W = 64
) (
	// Clock, reset and command side
	input wire aclk,
	input wire aresetn,
	input wire cmd_valid,
	input wire [2:0] cmd_class,
	input wire [7:0] cmd_p1,
	input wire [7:0] cmd_p2,
	input wire [95:0] cmd_data,
	input wire proactive_active,
	input wire bic_open,
	input wire secure_in_use,
	input wire [STATE_W-1:0] live_state,
	// Response side
	input wire rsp_valid,
	input wire [15:0] rsp_sw,
	input wire [79:0] rsp_data,
	input wire [3:0] rsp_len,
	input wire rsp_proactive_ok,
	input wire [STATE_W-1:0] saved_state,
	input wire save_pulse,
	input wire restore_pulse,
	input wire erase_pulse
);
	// ==========================================
	// Assertions
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire park = cmd_valid && cmd_class == 3'h0 && cmd_p1 == 8'h00 && cmd_p2 == 8'h00;
	wire busy = proactive_active || bic_open || secure_in_use;
	property p_busy; park && busy |=> rsp_valid && rsp_sw == 16'h6985; endproperty
	a_busy: assert property (p_busy) else $error("park taken while busy");
	property p_big; park && !busy && cmd_data[95:88] > 8'h04 |=> rsp_sw != 16'h9000; endproperty
	a_big: assert property (p_big) else $error("bad minimum accepted");
	property p_save; save_pulse |-> rsp_valid && rsp_sw == 16'h9000 && rsp_len == 4'ha
		&& !rsp_proactive_ok; endproperty
	a_save: assert property (p_save) else $error("park answer wrong");
	property p_grant; save_pulse |-> rsp_data[79:64] == $past(cmd_data[95:80])
		|| rsp_data[79:64] == $past(cmd_data[79:64]); endproperty
	a_grant: assert property (p_grant) else $error("grant outside range");
	property p_image; save_pulse |-> saved_state == $past(live_state); endproperty
	a_image: assert property (p_image) else $error("image not saved");
	property p_miss; rsp_valid && rsp_sw == 16'h6982 |-> erase_pulse && !restore_pulse; endproperty
	a_miss: assert property (p_miss) else $error("mismatch kept state");
	property p_other; cmd_valid && cmd_class == 3'h7 |=> rsp_sw == 16'h9000 && !restore_pulse;
	endproperty
	a_other: assert property (p_other) else $error("other command misread");
	property p_rfu; cmd_valid && cmd_class == 3'h0 && cmd_p1[7:1] != 7'h00
		|=> rsp_sw == 16'h6b00 && !save_pulse; endproperty
	a_rfu: assert property (p_rfu) else $error("reserved bits ignored");
endmodule
bind csr_handler csr_handler_sva #(.STATE_W(STATE_W)) csr_handler_sva_inst (.*);

// [tb/csr_term_model.sv]
// Purpose: Terminal that issues park, resume and other commands
// Assumes: One command per call, one cycle of valid
// Notes: Parks only as if the power capability file showed support
`timescale 1ns/1ps
module csr_term_model (
	// Clock
	input wire aclk,
	// Command toward the card
	output logic cmd_valid = 1'b0,
	output logic [135:0] cmd_bus = 136'h0
);
	// Fields go to their inverse after each command so stale bytes never look live
	task send(input [2:0] c, input [7:0] p1, input [7:0] lc, input [7:0] le, input [95:0] d);
		begin
			@(posedge aclk);
			cmd_valid <= 1'b1;
			cmd_bus <= {5'h00, c, p1, 8'h00, lc, le, d};
			@(posedge aclk);
			cmd_valid <= 1'b0;
			cmd_bus <= ~{5'h00, c, p1, 8'h00, lc, le, d};
			#1;
		end
	endtask
	// Contacts go down after an OK park; the bench does not model that and goes straight on to the next command
	task park(input [15:0] mn, input [15:0] mx);
		send(3'h0, 8'h00, 8'h04, 8'h0a, {mn, mx, 64'h0});
	endtask
	task resume(input [63:0] tok);
		send(3'h0, 8'h01, 8'h08, 8'h00, {tok, 32'h0});
	endtask
endmodule

// [tb/test_card_suspend_resume_handler.sv]
// Purpose: Self-checking bench of the park and resume handler
// Assumes: Responses one cycle after each command
// Notes: Maximum duration limit lowered to 300 s so both grant choices occur
`timescale 1ns/1ps
`include "csr_defs.vh"
module test_card_suspend_resume_handler;
	// ==========================================
	// Signals
	logic aclk = 1'b0, aresetn = 1'b0, proactive_active = 1'b0, bic_open = 1'b0;
	logic secure_in_use = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [63:0] live_state = 64'h0, tok;
	logic [15:0] r = 16'd49404, mn, mx;
	wire cmd_valid, cmd_ready, rsp_valid, rsp_proactive_ok, save_pulse, restore_pulse;
	wire discard_pulse, erase_pulse, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid;
	wire [135:0] cmd_bus;
	wire [15:0] rsp_sw;
	wire [79:0] rsp_data;
	wire [3:0] rsp_len;
	wire [63:0] saved_state;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] cmd_class = cmd_bus[130:128];
	wire [7:0] cmd_p1 = cmd_bus[127:120], cmd_p2 = cmd_bus[119:112];
	wire [7:0] cmd_lc = cmd_bus[111:104], cmd_le = cmd_bus[103:96];
	wire [95:0] cmd_data = cmd_bus[95:0];
	int miscompares = 0, n_checks = 0, i;
	csr_handler csr_handler_inst (.*);
	csr_term_model csr_term_model_inst (.aclk(aclk), .cmd_valid(cmd_valid), .cmd_bus(cmd_bus));
	initial forever #5 aclk = ~aclk;
	initial begin
		#500000;
		miscompares++;
		wrap_up;
	end
	// ==========================================
	// Helpers
	function [15:0] lfsr(input [15:0] s);
		lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function longint secs(input [15:0] d);
		secs = d[7:0] * (d[15:8] == 8'h0 ? 1 : d[15:8] == 8'h1 ? 60 : d[15:8] == 8'h2 ? 3600 :
			d[15:8] == 8'h3 ? 86400 : 864000);
	endfunction
	task chk(input logic [79:0] g, input logic [79:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("Error %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
			do begin
				@(posedge aclk);
				n++;
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_bvalid !== 1'b1 && n < 40);
			s_axi_bready <= 1'b0;
			chk({n < 40, s_axi_bresp}, 3'b100);
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		int n;
		begin
			n = 0;
			@(posedge aclk);
			{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
			do begin
				@(posedge aclk);
				n++;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (s_axi_rvalid !== 1'b1 && n < 40);
			s_axi_rready <= 1'b0;
			chk({n < 40, s_axi_rdata}, {1'b1, e});
		end
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`CSR_A_MAXDUR, 32'h0418);
		rd(`CSR_A_STATUS, 32'h0);
		chk(cmd_ready, 1'b1);
		wr(`CSR_A_MAXDUR, 32'h0105);
		for (i = 0; i < 3; i++) begin
			{proactive_active, bic_open, secure_in_use} <= 3'b100 >> i;
			csr_term_model_inst.park(16'h0001, 16'h0002);
			chk(rsp_sw, `CSR_SW_COND);
		end
		{proactive_active, bic_open, secure_in_use} <= 3'b000;
		wr(`CSR_A_CTRL, 32'h1);
		csr_term_model_inst.park(16'h0001, 16'h0002);
		chk(rsp_sw, `CSR_SW_COND);
		wr(`CSR_A_CTRL, 32'h0);
		csr_term_model_inst.park(16'h0106, 16'h0200);
		chk(rsp_sw, `CSR_SW_MINBIG);
		csr_term_model_inst.park(16'h0501, 16'h0501);
		chk(rsp_sw, `CSR_SW_MINBIG);
		csr_term_model_inst.send(3'h0, 8'h02, 8'h04, 8'h0a, 96'h0);
		chk(rsp_sw, `CSR_SW_PARAM);
		csr_term_model_inst.resume(64'h1);
		chk({rsp_valid, rsp_sw}, {1'b1, `CSR_SW_COND});
		for (i = 0; i < 9; i++) begin
			r = lfsr(r);
			live_state <= {r, ~r, r, ~r};
			mn = {8'h00, r[7:0]};
			mx = {6'h00, r[9:8], 8'hff};
			csr_term_model_inst.park(mn, mx);
			chk({rsp_sw, rsp_len, rsp_proactive_ok}, {`CSR_SW_OK, 4'ha, 1'b0});
			chk(rsp_data[79:64], secs(mx) <= 300 ? mx : mn);
			chk(saved_state, {r, ~r, r, ~r});
			tok = rsp_data[63:0];
			if (i % 3 == 0) csr_term_model_inst.resume(tok ^ 64'h1);
			if (i % 3 == 0) chk(rsp_sw, `CSR_SW_TOKEN);
			if (i % 3 == 1) csr_term_model_inst.send(3'h1, 8'h00, 8'h02, 8'h00, 96'h0);
			if (i % 3 == 1) csr_term_model_inst.send(3'h4, 8'h00, 8'h04, 8'h00, 96'h0);
			if (i % 3 == 1) csr_term_model_inst.resume(tok);
			if (i % 3 == 1) chk({rsp_sw, restore_pulse, discard_pulse}, {`CSR_SW_OK, 2'b11});
			if (i % 3 == 2) csr_term_model_inst.send(3'h7, 8'h00, 8'h00, 8'h00, 96'h0);
			if (i % 3 == 2) chk(erase_pulse, 1'b1);
			csr_term_model_inst.resume(tok);
			chk(rsp_sw, `CSR_SW_COND);
		end
		wrap_up;
	end
endmodule
